// >>> gpm_pkg.sv
// Operation
// - unbalance fault when phase deviates beyond percent
// - zero unbalance limit disables unbalance monitoring
// - unbalance action: none, shutdown, loaddump, warning
// - negative power beyond warning limit warns
// - negative power beyond loaddump limit dumps load
// - zero warning limit disables reverse power
// - reverse power must persist for fail time
// - overcurrent on primary limit while feeding load
// - secondary voltage set uses second limit
// - tertiary voltage set uses third limit
// - overcurrent action: shutdown or loaddump
// - larger time multiplier trips overcurrent faster
// - overload loaddump when feeding above limit
// - zero overload limit disables overload
// - overload must persist for fail time
// - shedding relay off below low limit
// - shedding relay on above high limit
// - minimum spacing between load add pulses
// - subtract to add delay in minutes
// - mains wait before releasing genset contactor
// - mains topology code, default star
// - genset topology code, same encodings
// - shutdown alarm also stops the engine
package gpm_pkg;

  // timing: one second tick at a 40 ns clock
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_TIME_NS  = 1_000_000_000;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam logic [7:0]  OC_TRIP_LEVEL = 8'h40; // overcurrent integrator trip point

  // register byte offsets
  localparam logic [7:0] OFS_UNBAL  = 8'h00;
  localparam logic [7:0] OFS_RPWARN = 8'h04;
  localparam logic [7:0] OFS_RPLD   = 8'h08;
  localparam logic [7:0] OFS_RPTIME = 8'h0C;
  localparam logic [7:0] OFS_OC1    = 8'h10;
  localparam logic [7:0] OFS_OC2    = 8'h14;
  localparam logic [7:0] OFS_OC3    = 8'h18;
  localparam logic [7:0] OFS_OCCFG  = 8'h1C;
  localparam logic [7:0] OFS_OLLIM  = 8'h20;
  localparam logic [7:0] OFS_OLTIME = 8'h24;
  localparam logic [7:0] OFS_SHLO   = 8'h28;
  localparam logic [7:0] OFS_SHHI   = 8'h2C;
  localparam logic [7:0] OFS_ADDDLY = 8'h30;
  localparam logic [7:0] OFS_SUBADD = 8'h34;
  localparam logic [7:0] OFS_MWAIT  = 8'h38;
  localparam logic [7:0] OFS_TOPO   = 8'h3C;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_CMD    = 8'h44;

  // field positions
  localparam int unsigned UNB_ACT_POS  = 8;  // unbalance action in UNBAL
  localparam int unsigned OC_MULT_POS  = 8;  // multiplier in OCCFG
  localparam int unsigned GTOPO_POS    = 4;  // genset topology in TOPO
  localparam int unsigned CMD_ADD_BIT  = 0;
  localparam int unsigned CMD_SUB_BIT  = 1;
  localparam int unsigned CMD_CLR_BIT  = 2;

  // reset values
  localparam logic [6:0]  RST_RP_TIME    = 7'h05;
  localparam logic [6:0]  RST_OC_MULT    = 7'h10;
  localparam logic [6:0]  RST_OL_TIME    = 7'h03;
  localparam logic [15:0] RST_MAINS_WAIT = 16'h001E;
  localparam logic [2:0]  RST_TOPO       = 3'h5;

  // fault bit indices
  localparam int unsigned F_UNB = 0;
  localparam int unsigned F_RPW = 1;
  localparam int unsigned F_RPL = 2;
  localparam int unsigned F_OC  = 3;
  localparam int unsigned F_OL  = 4;

  // unbalance actions
  typedef enum logic [1:0] {
    UACT_NONE     = 2'b00,
    UACT_SHUTDOWN = 2'b01,
    UACT_LOADDUMP = 2'b10,
    UACT_WARNING  = 2'b11
  } gpm_uact_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } gpm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } gpm_apb_rsp_t;

  // measurements, produced on the same clock
  typedef struct packed {
    logic [15:0]        i_l1;      // phase currents, amps
    logic [15:0]        i_l2;
    logic [15:0]        i_l3;
    logic signed [17:0] power_kw;  // genset active power, signed
    logic               feeding;   // genset feeds the load
    logic [1:0]         volt_set;  // 0 primary, 1 secondary, 2 tertiary
    logic               mains_ok;  // mains voltage and frequency in limits
  } gpm_meas_t;

  typedef struct packed {
    logic       engine_stop;
    logic       shutdown;
    logic       loaddump;
    logic       warning;
    logic       shed_relay;
    logic       load_add;
    logic       load_sub;
    logic       mains_return;
    logic [2:0] mains_topo;
    logic [2:0] gen_topo;
  } gpm_out_t;

  typedef struct packed {
    logic [6:0]       unb_lim;
    gpm_uact_t        unb_act;
    logic [15:0]      rp_warn;
    logic [15:0]      rp_ld;
    logic [6:0]       rp_time;
    logic [2:0][15:0] oc_lim;
    logic             oc_act;
    logic [6:0]       oc_mult;
    logic [15:0]      ol_lim;
    logic [6:0]       ol_time;
    logic [15:0]      shed_lo;
    logic [15:0]      shed_hi;
    logic [7:0]       add_dly;
    logic [6:0]       subadd_dly;
    logic [15:0]      mains_wait;
    logic [2:0]       mains_topo;
    logic [2:0]       gen_topo;
  } gpm_cfg_t;

endpackage

// >>> gpm_top.sv
`timescale 1ns/1ns
`default_nettype none

module gpm_top #(
  parameter int unsigned TICK_CYCLES = gpm_pkg::TICK_CYCLES  // clocks per second tick
) (
  input  wire logic                  CLOCK,
  input  wire logic                  SYS_RST,
  input  wire gpm_pkg::gpm_apb_req_t APB_REQ,
  output var  gpm_pkg::gpm_apb_rsp_t APB_RSP,
  input  wire gpm_pkg::gpm_meas_t    MEAS,
  output var  gpm_pkg::gpm_out_t     PM_OUT
);
  import gpm_pkg::*;

  // the tick counter is 32 bits wide; a one-cycle tick would hold tick high in every cycle
  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // whole state of the block
  typedef struct packed {
    gpm_cfg_t    cfg;         // programmed limits
    logic [31:0] tick_cnt;    // divider for the second tick
    logic [6:0]  rpw_cnt;     // reverse power warning persistence, seconds
    logic [6:0]  rpl_cnt;     // reverse power loaddump persistence, seconds
    logic [6:0]  ol_cnt;      // overload persistence, seconds
    logic [7:0]  oc_acc;      // overcurrent integrator
    logic [4:0]  fault;       // latched faults
    logic        add_pend;    // load add requested, not yet issued
    logic [7:0]  since_add;   // seconds since last add pulse, saturating
    logic [5:0]  sub_sec;     // seconds within current minute after subtract
    logic [6:0]  since_sub;   // minutes since last subtract pulse, saturating
    logic [15:0] mains_cnt;   // seconds mains has been healthy
    gpm_out_t    out;
    gpm_apb_rsp_t rsp;
  } gpm_state_t;

  gpm_state_t st_ff;   // registered state
  gpm_state_t nxt_st;  // next state

  // configuration after reset
  function automatic gpm_cfg_t cfg_reset();
    gpm_cfg_t c;
    c            = '0;
    c.unb_act    = UACT_NONE;
    c.rp_time    = RST_RP_TIME;
    c.oc_mult    = RST_OC_MULT;
    c.ol_time    = RST_OL_TIME;
    c.mains_wait = RST_MAINS_WAIT;
    c.mains_topo = RST_TOPO;
    c.gen_topo   = RST_TOPO;
    return c;
  endfunction

  // whole state after reset; constants only, so the async branch stays clean
  function automatic gpm_state_t st_reset();
    gpm_state_t s;
    s                = '0;
    s.cfg            = cfg_reset();
    s.since_add      = 8'hFF;     // adds allowed at once
    s.since_sub      = 7'h7F;
    s.out.mains_topo = RST_TOPO;
    s.out.gen_topo   = RST_TOPO;
    return s;
  endfunction

  // saturating persistence counter step
  function automatic logic [6:0] persist(input logic [6:0] cnt, input logic cond,
                                         input logic tick);
    if (!cond) begin
      return 7'h00;
    end
    return (tick && cnt != 7'h7F) ? cnt + 7'h01 : cnt;
  endfunction

  // register read decode; unmapped addresses read zero
  function automatic logic [31:0] rd_word(input gpm_state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = '0;
    unique case (a)
      OFS_UNBAL:  begin
        d[6:0] = s.cfg.unb_lim;
        d[UNB_ACT_POS +: 2] = s.cfg.unb_act;
      end
      OFS_RPWARN: d[15:0] = s.cfg.rp_warn;
      OFS_RPLD:   d[15:0] = s.cfg.rp_ld;
      OFS_RPTIME: d[6:0]  = s.cfg.rp_time;
      OFS_OC1:    d[15:0] = s.cfg.oc_lim[0];
      OFS_OC2:    d[15:0] = s.cfg.oc_lim[1];
      OFS_OC3:    d[15:0] = s.cfg.oc_lim[2];
      OFS_OCCFG:  begin
        d[0] = s.cfg.oc_act;
        d[OC_MULT_POS +: 7] = s.cfg.oc_mult;
      end
      OFS_OLLIM:  d[15:0] = s.cfg.ol_lim;
      OFS_OLTIME: d[6:0]  = s.cfg.ol_time;
      OFS_SHLO:   d[15:0] = s.cfg.shed_lo;
      OFS_SHHI:   d[15:0] = s.cfg.shed_hi;
      OFS_ADDDLY: d[7:0]  = s.cfg.add_dly;
      OFS_SUBADD: d[6:0]  = s.cfg.subadd_dly;
      OFS_MWAIT:  d[15:0] = s.cfg.mains_wait;
      OFS_TOPO:   begin
        d[2:0] = s.cfg.mains_topo;
        d[GTOPO_POS +: 3] = s.cfg.gen_topo;
      end
      OFS_STATUS: begin
        d[4:0] = s.fault;
        d[8]   = s.out.shutdown;
        d[9]   = s.out.loaddump;
        d[10]  = s.out.warning;
        d[11]  = s.out.shed_relay;
        d[12]  = s.out.mains_return;
        d[13]  = s.add_pend;
      end
      default:    d = '0;
    endcase
    return d;
  endfunction

  // address is one of the mapped words
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_CMD);
  endfunction

  // combinational next state
  always_comb begin
    logic        tick;
    logic        wr;
    logic [31:0] wd;
    logic [17:0] sum_i;
    logic [17:0] i3x [3];
    logic [24:0] dev;
    logic [24:0] allow;
    logic        unb_now;
    logic [16:0] rev_kw;
    logic        neg;
    logic [15:0] oc_sel;
    logic        oc_over;
    logic [8:0]  acc_sum;
    logic        ol_over;
    logic [4:0]  raise;
    logic        clr;
    logic        add_ok;
    tick    = 1'b0;
    wr      = 1'b0;
    wd      = '0;
    sum_i   = '0;
    i3x     = '{default: '0};
    dev     = '0;
    allow   = '0;
    unb_now = 1'b0;
    rev_kw  = '0;
    neg     = 1'b0;
    oc_sel  = '0;
    oc_over = 1'b0;
    acc_sum = '0;
    ol_over = 1'b0;
    raise   = '0;
    clr     = 1'b0;
    add_ok  = 1'b0;
    nxt_st  = st_ff;

    // second tick divider
    if (st_ff.tick_cnt == TICK_LAST) begin
      nxt_st.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h00000001;
    end

    // apb slave: ready in the first access cycle, data prepared in setup
    nxt_st.rsp.pready  = APB_REQ.psel && !APB_REQ.penable;
    nxt_st.rsp.prdata  = rd_word(st_ff, APB_REQ.paddr);
    nxt_st.rsp.pslverr = APB_REQ.psel && !APB_REQ.penable && !is_mapped(APB_REQ.paddr);
    wr = APB_REQ.psel && APB_REQ.penable && st_ff.rsp.pready && APB_REQ.pwrite
         && !st_ff.rsp.pslverr;
    wd = APB_REQ.pwdata;
    if (wr) begin
      unique case (APB_REQ.paddr)
        OFS_UNBAL:  begin
          nxt_st.cfg.unb_lim = wd[6:0];
          nxt_st.cfg.unb_act = gpm_uact_t'(wd[UNB_ACT_POS +: 2]);
        end
        OFS_RPWARN: nxt_st.cfg.rp_warn = wd[15:0];
        OFS_RPLD:   nxt_st.cfg.rp_ld   = wd[15:0];
        OFS_RPTIME: nxt_st.cfg.rp_time = wd[6:0];
        OFS_OC1:    nxt_st.cfg.oc_lim[0] = wd[15:0];
        OFS_OC2:    nxt_st.cfg.oc_lim[1] = wd[15:0];
        OFS_OC3:    nxt_st.cfg.oc_lim[2] = wd[15:0];
        OFS_OCCFG:  begin
          nxt_st.cfg.oc_act  = wd[0];
          nxt_st.cfg.oc_mult = wd[OC_MULT_POS +: 7];
        end
        OFS_OLLIM:  nxt_st.cfg.ol_lim     = wd[15:0];
        OFS_OLTIME: nxt_st.cfg.ol_time    = wd[6:0];
        OFS_SHLO:   nxt_st.cfg.shed_lo    = wd[15:0];
        OFS_SHHI:   nxt_st.cfg.shed_hi    = wd[15:0];
        OFS_ADDDLY: nxt_st.cfg.add_dly    = wd[7:0];
        OFS_SUBADD: nxt_st.cfg.subadd_dly = wd[6:0];
        OFS_MWAIT:  nxt_st.cfg.mains_wait = wd[15:0];
        OFS_TOPO:   begin
          nxt_st.cfg.mains_topo = wd[2:0];
          nxt_st.cfg.gen_topo   = wd[GTOPO_POS +: 3];
        end
        OFS_CMD:    clr = wd[CMD_CLR_BIT];
        default:    ;  // status is read only
      endcase
    end

    // unbalance: |3*Ix - sum| * 100 > limit * sum, no divider needed
    sum_i = 18'(MEAS.i_l1) + 18'(MEAS.i_l2) + 18'(MEAS.i_l3);
    i3x[0] = 18'(MEAS.i_l1) * 18'h00003;
    i3x[1] = 18'(MEAS.i_l2) * 18'h00003;
    i3x[2] = 18'(MEAS.i_l3) * 18'h00003;
    allow = 25'(st_ff.cfg.unb_lim) * 25'(sum_i);
    for (int k = 0; k < 3; k++) begin
      dev = (i3x[k] > sum_i) ? 25'(i3x[k] - sum_i) : 25'(sum_i - i3x[k]);
      if (dev * 25'h0000064 > allow) begin
        unb_now = 1'b1;
      end
    end
    raise[F_UNB] = unb_now && (st_ff.cfg.unb_lim != 7'h00);

    // reverse power, both levels gated by the warning limit
    neg    = MEAS.power_kw < 0;
    rev_kw = neg ? 17'(-MEAS.power_kw) : 17'h00000;
    nxt_st.rpw_cnt = persist(st_ff.rpw_cnt, neg && rev_kw > 17'(st_ff.cfg.rp_warn)
                             && st_ff.cfg.rp_warn != 16'h0000, tick);
    nxt_st.rpl_cnt = persist(st_ff.rpl_cnt, neg && rev_kw > 17'(st_ff.cfg.rp_ld)
                             && st_ff.cfg.rp_warn != 16'h0000, tick);
    raise[F_RPW] = neg && rev_kw > 17'(st_ff.cfg.rp_warn) && st_ff.cfg.rp_warn != 16'h0000
                   && st_ff.rpw_cnt >= st_ff.cfg.rp_time;
    raise[F_RPL] = neg && rev_kw > 17'(st_ff.cfg.rp_ld) && st_ff.cfg.rp_warn != 16'h0000
                   && st_ff.rpl_cnt >= st_ff.cfg.rp_time;

    // overcurrent limit follows the selected voltage set
    unique case (MEAS.volt_set)
      2'b01:   oc_sel = st_ff.cfg.oc_lim[1];
      2'b10:   oc_sel = st_ff.cfg.oc_lim[2];
      default: oc_sel = st_ff.cfg.oc_lim[0];
    endcase
    oc_over = MEAS.feeding && oc_sel != 16'h0000 && (MEAS.i_l1 > oc_sel
              || MEAS.i_l2 > oc_sel || MEAS.i_l3 > oc_sel);
    // integrator: each second over limit adds the multiplier, so a larger one trips sooner
    acc_sum = 9'(st_ff.oc_acc) + 9'(st_ff.cfg.oc_mult);
    if (!oc_over) begin
      nxt_st.oc_acc = 8'h00;
    end else if (tick) begin
      nxt_st.oc_acc = (acc_sum > 9'(OC_TRIP_LEVEL)) ? OC_TRIP_LEVEL : acc_sum[7:0];
    end
    raise[F_OC] = oc_over && st_ff.oc_acc >= OC_TRIP_LEVEL;

    // overload, total active power
    ol_over = MEAS.feeding && st_ff.cfg.ol_lim != 16'h0000
              && MEAS.power_kw > $signed({2'b00, st_ff.cfg.ol_lim});
    nxt_st.ol_cnt = persist(st_ff.ol_cnt, ol_over, tick);
    raise[F_OL] = ol_over && st_ff.ol_cnt >= st_ff.cfg.ol_time;

    // latched faults: a new fault wins over a clear in the same cycle
    nxt_st.fault = (clr ? 5'h00 : st_ff.fault) | raise;

    // actions from the latched faults
    nxt_st.out.shutdown = (nxt_st.fault[F_UNB] && st_ff.cfg.unb_act == UACT_SHUTDOWN)
                          || (nxt_st.fault[F_OC] && !st_ff.cfg.oc_act);
    nxt_st.out.loaddump = (nxt_st.fault[F_UNB] && st_ff.cfg.unb_act == UACT_LOADDUMP)
                          || (nxt_st.fault[F_OC] && st_ff.cfg.oc_act)
                          || nxt_st.fault[F_RPL] || nxt_st.fault[F_OL];
    nxt_st.out.warning  = (nxt_st.fault[F_UNB] && st_ff.cfg.unb_act == UACT_WARNING)
                          || nxt_st.fault[F_RPW];
    nxt_st.out.engine_stop = nxt_st.out.shutdown;

    // load shedding relay with hysteresis
    if (MEAS.power_kw < $signed({2'b00, st_ff.cfg.shed_lo})) begin
      nxt_st.out.shed_relay = 1'b0;
    end else if (MEAS.power_kw > $signed({2'b00, st_ff.cfg.shed_hi})) begin
      nxt_st.out.shed_relay = 1'b1;
    end

    // spacing timers, saturating
    if (tick && st_ff.since_add != 8'hFF) begin
      nxt_st.since_add = st_ff.since_add + 8'h01;
    end
    if (tick && st_ff.since_sub != 7'h7F) begin
      if (st_ff.sub_sec == 6'(SEC_PER_MIN - 1)) begin
        nxt_st.sub_sec   = 6'h00;
        nxt_st.since_sub = st_ff.since_sub + 7'h01;
      end else begin
        nxt_st.sub_sec = st_ff.sub_sec + 6'h01;
      end
    end

    // pulses clear at the next tick, so last up to one tick period
    if (tick) begin
      nxt_st.out.load_add = 1'b0;
      nxt_st.out.load_sub = 1'b0;
    end
    if (wr && APB_REQ.paddr == OFS_CMD && wd[CMD_SUB_BIT]) begin
      nxt_st.out.load_sub = 1'b1;
      nxt_st.since_sub    = 7'h00;
      nxt_st.sub_sec      = 6'h00;
    end
    add_ok = st_ff.since_add >= st_ff.cfg.add_dly
             && st_ff.since_sub >= st_ff.cfg.subadd_dly
             && !(wr && APB_REQ.paddr == OFS_CMD && wd[CMD_SUB_BIT])
             && !st_ff.out.load_sub;
    if (st_ff.add_pend && add_ok) begin
      nxt_st.add_pend     = 1'b0;
      nxt_st.out.load_add = 1'b1;
      nxt_st.since_add    = 8'h00;
    end
    // a request written while one is issued stays pending
    if (wr && APB_REQ.paddr == OFS_CMD && wd[CMD_ADD_BIT]) begin
      nxt_st.add_pend = 1'b1;
    end

    // mains return waiting timer
    if (!MEAS.mains_ok) begin
      nxt_st.mains_cnt        = 16'h0000;
      nxt_st.out.mains_return = 1'b0;
    end else if (st_ff.mains_cnt >= st_ff.cfg.mains_wait) begin
      nxt_st.out.mains_return = 1'b1;
    end else if (tick) begin
      nxt_st.mains_cnt = st_ff.mains_cnt + 16'h0001;
    end

    nxt_st.out.mains_topo = nxt_st.cfg.mains_topo;
    nxt_st.out.gen_topo   = nxt_st.cfg.gen_topo;
  end

  // state register
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff <= st_reset();
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign APB_RSP = st_ff.rsp;
  assign PM_OUT  = st_ff.out;

endmodule

`default_nettype wire

// >>> gpm_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
// watches the top ports only; alarm latches, pulses and copies
module gpm_top_chk #(
  parameter int unsigned TICK_CYCLES = 10  // clocks per second tick
) (
  input wire logic                  CLOCK,
  input wire logic                  SYS_RST,
  input wire gpm_pkg::gpm_apb_req_t APB_REQ,
  input wire gpm_pkg::gpm_apb_rsp_t APB_RSP,
  input wire gpm_pkg::gpm_meas_t    MEAS,
  input wire gpm_pkg::gpm_out_t     PM_OUT
);
  import gpm_pkg::*;
  logic wr;   // a write completes at this edge
  logic clr;  // fault clear command completes
  logic sub;  // subtract request completes
  logic topo; // topology write completes
  assign wr   = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && APB_RSP.pready;
  assign clr  = wr && APB_REQ.paddr == OFS_CMD && APB_REQ.pwdata[CMD_CLR_BIT];
  assign sub  = wr && APB_REQ.paddr == OFS_CMD && APB_REQ.pwdata[CMD_SUB_BIT];
  assign topo = wr && APB_REQ.paddr == OFS_TOPO;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  property p_stop; PM_OUT.shutdown |-> PM_OUT.engine_stop; endproperty
  a_stop: assert property (p_stop)
    else $error("shutdown without engine stop");
  property p_sd; PM_OUT.shutdown && !clr |=> PM_OUT.shutdown; endproperty
  a_sd: assert property (p_sd)
    else $error("shutdown dropped without clear");
  property p_ld; PM_OUT.loaddump && !clr |=> PM_OUT.loaddump; endproperty
  a_ld: assert property (p_ld)
    else $error("loaddump dropped without clear");
  property p_wn; PM_OUT.warning && !clr |=> PM_OUT.warning; endproperty
  a_wn: assert property (p_wn)
    else $error("warning dropped without clear");
  property p_mr; !MEAS.mains_ok |=> !PM_OUT.mains_return; endproperty
  a_mr: assert property (p_mr)
    else $error("mains return without mains");
  property p_sub; sub |-> ##[1:2] PM_OUT.load_sub; endproperty
  a_sub: assert property (p_sub)
    else $error("no subtract pulse");
  property p_mt; !topo |=> $stable(PM_OUT.mains_topo); endproperty
  a_mt: assert property (p_mt)
    else $error("mains topology moved");
  property p_gt; !topo |=> $stable(PM_OUT.gen_topo); endproperty
  a_gt: assert property (p_gt)
    else $error("genset topology moved");
  c_sd: cover property (PM_OUT.shutdown);
  c_add: cover property ($rose(PM_OUT.load_add));
  c_mr: cover property ($rose(PM_OUT.mains_return));
endmodule
bind gpm_top gpm_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.CLOCK(CLOCK),
  .SYS_RST(SYS_RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .MEAS(MEAS), .PM_OUT(PM_OUT));
`default_nettype wire

// >>> gpm_plant.sv
`timescale 1ns/1ns
`default_nettype none
// measurement front end: shows the set values one clock later
module gpm_plant (
  input  wire logic               clock,
  input  wire gpm_pkg::gpm_meas_t set_val,
  output var  gpm_pkg::gpm_meas_t meas
);
  import gpm_pkg::*;
  gpm_meas_t meas_ff = '0;  // converter output, defined from time zero
  gpm_meas_t nxt_meas;      // next converter sample
  // one conversion per clock, so the block never sees a mid-change value
  always_comb begin
    nxt_meas = set_val;
  end
  always @(posedge clock) begin
    meas_ff <= nxt_meas;
  end
  assign meas = meas_ff;
endmodule
`default_nettype wire

// >>> gpm_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_top_tb;
  import gpm_pkg::*;
  localparam int unsigned TK = 10;  // short tick keeps the run brief
  localparam gpm_meas_t NEU = '{16'h64, 16'h64, 16'h64, 18'h0, 1'b1, 2'h0, 1'b0};
  logic         clock   = 1'b0;
  logic         sys_rst = 1'b1;
  gpm_apb_req_t req     = '0;
  gpm_apb_rsp_t rsp;
  gpm_meas_t    set_val = NEU;
  gpm_meas_t    meas;
  gpm_out_t     po;
  logic [31:0]  rd;
  logic         err, la_q, ls_q, shed;
  int           fails = 0, checks = 0, cyc = 0, n_add = 0, n_sub = 0, k, p;
  logic [7:0]   ra [5] = '{OFS_RPTIME, OFS_OCCFG, OFS_OLTIME, OFS_MWAIT, OFS_TOPO};
  logic [31:0]  rv [5] = '{32'h5, 32'h1000, 32'h3, 32'h1E, 32'h55};
  always #20 clock = ~clock;
  gpm_plant i_plant (.clock(clock), .set_val(set_val), .meas(meas));
  gpm_top #(.TICK_CYCLES(TK)) i_dut (.CLOCK(clock), .SYS_RST(sys_rst), .APB_REQ(req),
    .APB_RSP(rsp), .MEAS(meas), .PM_OUT(po));
  // timeout and pulse counters; pulses may be one clock, so count edges
  always @(posedge clock) begin
    cyc <= cyc + 1;
    la_q <= po.load_add;
    ls_q <= po.load_sub;
    if (po.load_add === 1'b1 && la_q !== 1'b1) n_add <= n_add + 1;
    if (po.load_sub === 1'b1 && ls_q !== 1'b1) n_sub <= n_sub + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  function automatic logic [31:0] outs();
    return {28'h0, po.engine_stop, po.shutdown, po.loaddump, po.warning};
  endfunction
  // expected alarm set per unbalance action code
  function automatic logic [31:0] act_exp(input int a);
    case (a)
      1: return 32'hC;
      2: return 32'h2;
      3: return 32'h1;
      default: return 32'h0;
    endcase
  endfunction
  // hysteresis: low limit 100, high limit 300, hold between
  function automatic logic shed_exp(input int v, input logic prev);
    if (v < 100) return 1'b0;
    if (v > 300) return 1'b1;
    return prev;
  endfunction
  // remove the cause first so the clear is not overruled
  task automatic clr;
    set_val <= NEU;
    w(3);
    wr(OFS_CMD, 32'h4);
    w(3);
    chk(outs(), 32'h0);
  endtask
  initial begin
    void'($urandom(32'hA383));
    w(10);
    sys_rst <= 1'b0;
    w(1);
    chk(32'({po.gen_topo, po.mains_topo}), 32'h2D);
    foreach (ra[i]) begin
      rdr(ra[i]);
      chk(rd, rv[i]);
    end
    rdr(8'h80);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    wr(OFS_TOPO, 32'h72);
    w(2);
    chk(32'({po.gen_topo, po.mains_topo}), 32'h3A);
    // 130 A against two 100 A phases is about 18 percent off
    set_val.i_l3 <= 16'h82;
    w(5);
    chk(outs(), 32'h0);
    for (int a = 0; a < 4; a++) begin
      wr(OFS_UNBAL, (32'(a) << UNB_ACT_POS) | 32'hA);
      set_val.i_l3 <= 16'h82;
      w(5);
      chk(outs(), act_exp(a));
      clr;
    end
    wr(OFS_UNBAL, 32'h0);
    // reverse power: warn 100, dump 200, two seconds
    wr(OFS_RPWARN, 32'h64);
    wr(OFS_RPLD, 32'hC8);
    wr(OFS_RPTIME, 32'h2);
    set_val.power_kw <= -18'sh96;
    w(TK - 2);
    chk(outs(), 32'h0);
    w(2 * TK + 10);
    chk(outs(), 32'h1);
    set_val.power_kw <= -18'shFA;
    w(3 * TK + 10);
    chk(outs(), 32'h3);
    clr;
    wr(OFS_RPWARN, 32'h0);
    set_val.power_kw <= -18'shFA;
    w(4 * TK);
    chk(outs(), 32'h0);
    clr;
    // overcurrent limits 500, 1000, 400; multiplier 16 first
    wr(OFS_OC1, 32'h1F4);
    wr(OFS_OC2, 32'h3E8);
    wr(OFS_OC3, 32'h190);
    wr(OFS_OCCFG, 32'h1000);
    set_val.i_l2 <= 16'h258;
    set_val.volt_set <= 2'h1;
    w(4 * TK);
    chk(outs(), 32'h0);
    set_val.volt_set <= 2'h0;
    set_val.feeding <= 1'b0;
    w(3 * TK);
    chk(outs(), 32'h0);
    set_val.feeding <= 1'b1;
    w(2 * TK);
    chk(outs(), 32'h0);
    w(3 * TK + 10);
    chk(outs(), 32'hC);
    clr;
    wr(OFS_OCCFG, 32'h4001);
    set_val.i_l2 <= 16'h1C2;
    set_val.volt_set <= 2'h2;
    w(2 * TK + 10);
    chk(outs(), 32'h2);
    clr;
    // overload 1000 kW with the default three second time
    wr(OFS_OLLIM, 32'h3E8);
    set_val.power_kw <= 18'h5DC;
    w(2 * TK - 2);
    chk(outs(), 32'h0);
    w(2 * TK + 10);
    chk(outs(), 32'h2);
    clr;
    wr(OFS_OLLIM, 32'h0);
    set_val.power_kw <= 18'h5DC;
    w(4 * TK);
    chk(outs(), 32'h0);
    wr(OFS_SHLO, 32'h64);
    wr(OFS_SHHI, 32'h12C);
    w(3);
    shed = 1'b1;
    for (int i = 0; i < 40; i++) begin
      p = $urandom_range(400, 0);
      set_val.power_kw <= 18'(p);
      w(3);
      shed = shed_exp(p, shed);
      chk({31'h0, po.shed_relay}, {31'h0, shed});
    end
    // five second add spacing
    wr(OFS_ADDDLY, 32'h5);
    k = n_add;
    wr(OFS_CMD, 32'h1);
    w(TK + 5);
    chk(32'(n_add - k), 32'h1);
    wr(OFS_CMD, 32'h1);
    w(TK / 2);
    chk(32'(n_add - k), 32'h1);
    w(4 * TK + 10);
    chk(32'(n_add - k), 32'h2);
    // one minute from subtract to add
    wr(OFS_ADDDLY, 32'h0);
    wr(OFS_SUBADD, 32'h1);
    k = n_sub;
    wr(OFS_CMD, 32'h2);
    w(TK + 5);
    chk(32'(n_sub - k), 32'h1);
    k = n_add;
    wr(OFS_CMD, 32'h1);
    w(30 * TK);
    chk(32'(n_add - k), 32'h0);
    w(35 * TK);
    chk(32'(n_add - k), 32'h1);
    wr(OFS_MWAIT, 32'h2);
    set_val.mains_ok <= 1'b1;
    w(TK - 2);
    chk({31'h0, po.mains_return}, 32'h0);
    w(2 * TK + 10);
    chk({31'h0, po.mains_return}, 32'h1);
    set_val.mains_ok <= 1'b0;
    w(3);
    chk({31'h0, po.mains_return}, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
